//--- inc/bdm_regs.svh
`ifndef BDM_REGS_SVH
`define BDM_REGS_SVH

// ----------------------------------------
// Unbanked core locations
// ----------------------------------------
`define BDM_ADDR_IND0      8'h00
`define BDM_ADDR_PTR0      8'h01
`define BDM_ADDR_ALU       8'h04
`define BDM_ADDR_IND1      8'h08
`define BDM_ADDR_PTR1      8'h09
`define BDM_ADDR_BANK      8'h0f
`define BDM_ADDR_PROD_LO   8'h18
`define BDM_ADDR_PROD_HI   8'h19

// ----------------------------------------
// Region bounds
// ----------------------------------------
`define BDM_PER_BANKED_TAG 5'h02
`define BDM_RAM_BANKED_LO  8'h20

// ----------------------------------------
// Flag and bank select register fields
// ----------------------------------------
`define BDM_FLAG_CARRY     0
`define BDM_FLAG_HALF      1
`define BDM_FLAG_NULL      2
`define BDM_FLAG_RANGE     3
`define BDM_PTR0_MODE_LO   4
`define BDM_PTR1_MODE_LO   6
`define BDM_RAM_BANK_LO    4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BDM_ALU_RESET      8'hf0
`define BDM_BANK_RESET     8'h00
`define BDM_PTR_RESET      8'h00
`define BDM_PROD_RESET     8'h00

`endif

//--- inc/bdm_pkg.sv
package bdm_pkg;

    // Operations issued by the instruction stream
    typedef enum logic [4:0] {
        OP_W_TO_FILE,
        OP_FILE_READ,
        OP_PER_TO_FILE,
        OP_FILE_TO_PER,
        OP_BANK_PER,
        OP_BANK_RAM,
        OP_ADD,
        OP_SUB,
        OP_AND,
        OP_IOR,
        OP_XOR,
        OP_CLR,
        OP_INC,
        OP_DEC,
        OP_RLC,
        OP_RRC,
        OP_MUL
    } bdm_op_t;

    // Sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } bdm_state_t;

endpackage

//--- inc/bdm_mem_if.sv
interface bdm_mem_if #(parameter int AW = 10);
    logic [AW-1:0] rd_addr;
    logic [AW-1:0] wr_addr;
    logic          wr_en;
    logic [7:0]    wr_data;
    logic [7:0]    rd_data;

    modport ctrl (output rd_addr, output wr_addr, output wr_en, output wr_data,
                  input rd_data);
    modport mem  (input rd_addr, input wr_addr, input wr_en, input wr_data,
                  output rd_data);
endinterface

//--- design/bdm_ram.sv
module bdm_ram #(
    parameter int AW = 10
) (
    input  logic          clk,
    bdm_mem_if.mem        bus
);

    logic [7:0] mem_q [0:(1<<AW)-1];

    // Byte write, no reset so contents survive every reset
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Registered read
    always_ff @(posedge clk) begin
        bus.rd_data <= mem_q[bus.rd_addr];
    end

endmodule

//--- design/bdm_core.sv
`include "bdm_regs.svh"

// What this block does
// - Bank select register widens general RAM past 224
// - Unbanked locations ignore bank select bits
// - Peripheral range 0-1F, file range 0-FF
// - Spare peripheral locations act as plain RAM
// - Indirect accesses also apply bank select bits
// - Every RAM location is eight bits wide
// - RAM never initialised nor changed by reset
// - Peripheral locations 10-17 banked, core registers unbanked
// - Literal loads set peripheral and RAM banks
// - Flag-affecting op on flags register: logic wins
// - Pointer one mode: decrement, increment or hold
// - Pointer zero mode: decrement, increment or hold
// - Range flag marks signed result out of range
// - Subtraction carries mean no borrow
// - Operands: W, file register or literal
module bdm_core #(
    parameter int BW = 2
) (
    input  logic             CLK,
    input  logic             RST_B,
    input  logic             OP_VALID,
    input  bdm_pkg::bdm_op_t OP_CODE,
    input  logic [7:0]       OP_FILE,
    input  logic [4:0]       OP_PERIPH,
    input  logic [7:0]       OP_LIT,
    input  logic             OP_IMM,
    input  logic             OP_TO_FILE,
    input  logic [7:0]       OP_WREG,
    output logic             OP_READY,
    output logic             DONE,
    output logic [7:0]       RESULT,
    output logic [7:0]       ALU_FLAGS,
    output logic [7:0]       BANK_SEL
);
    import bdm_pkg::*;

    localparam int AW = BW + 8;

    // ----------------------------------------
    // Address helpers
    // ----------------------------------------

    // Indirect slots resolve to the pointer value
    function automatic logic [7:0] resolve(input logic [7:0] a,
                                           input logic [7:0] p0,
                                           input logic [7:0] p1);
        logic [7:0] r;
        r = a;
        if (a == `BDM_ADDR_IND0) begin
            r = p0;
        end else if (a == `BDM_ADDR_IND1) begin
            r = p1;
        end
        return r;
    endfunction

    // Physical address: bank tag above the 8-bit location
    function automatic logic [AW-1:0] phys(input logic [7:0] a,
                                           input logic [7:0] bank);
        logic [BW-1:0] bk;
        bk = '0;
        if (a[7:3] == `BDM_PER_BANKED_TAG) begin
            bk = bank[BW-1:0];
        end else if (a >= `BDM_RAM_BANKED_LO) begin
            bk = bank[`BDM_RAM_BANK_LO +: BW];
        end
        return {bk, a};
    endfunction

    // Locations held in flops rather than RAM
    function automatic logic special(input logic [7:0] a);
        return (a == `BDM_ADDR_IND0) || (a == `BDM_ADDR_IND1) ||
               (a == `BDM_ADDR_PTR0) || (a == `BDM_ADDR_PTR1) ||
               (a == `BDM_ADDR_ALU)  || (a == `BDM_ADDR_BANK) ||
               (a == `BDM_ADDR_PROD_LO) || (a == `BDM_ADDR_PROD_HI);
    endfunction

    // Two-operand operations
    function automatic logic two_op(input bdm_op_t op);
        return (op == OP_ADD) || (op == OP_SUB) || (op == OP_AND) ||
               (op == OP_IOR) || (op == OP_XOR) || (op == OP_MUL);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    bdm_state_t state_q;
    bdm_op_t    op_q;
    logic [7:0] src_q;
    logic [7:0] dst_q;
    logic       wr_q;
    logic       use0_q;
    logic       use1_q;
    logic [7:0] lit_q;
    logic [7:0] w_q;
    logic       imm_q;
    logic       ready_q;
    logic       done_q;
    logic [7:0] result_q;
    logic [7:0] alu_q;
    logic [7:0] bank_q;
    logic [7:0] ptr0_q;
    logic [7:0] ptr1_q;
    logic [7:0] prod_lo_q;
    logic [7:0] prod_hi_q;

    bdm_mem_if #(.AW(AW)) mem_bus ();

    // RAM array, contents outside reset
    bdm_ram #(.AW(AW)) u_ram (
        .clk (CLK),
        .bus (mem_bus)
    );

    // ----------------------------------------
    // Issue decode
    // ----------------------------------------
    logic [7:0] src_raw;
    logic [7:0] dst_raw;
    logic [7:0] src_eff;
    logic [7:0] dst_eff;
    logic       rd_i;
    logic       wr_i;
    logic       take;

    assign take = OP_VALID && ready_q;

    // Pick source and destination for the operation
    always_comb begin
        src_raw = OP_FILE;
        dst_raw = OP_FILE;
        if (OP_CODE == OP_PER_TO_FILE) begin
            src_raw = {3'h0, OP_PERIPH};
        end
        if (OP_CODE == OP_FILE_TO_PER) begin
            dst_raw = {3'h0, OP_PERIPH};
        end
        unique case (OP_CODE)
            OP_W_TO_FILE: begin
                rd_i = 1'b0;
                wr_i = 1'b1;
            end
            OP_PER_TO_FILE, OP_FILE_TO_PER: begin
                rd_i = 1'b1;
                wr_i = 1'b1;
            end
            OP_BANK_PER, OP_BANK_RAM: begin
                rd_i = 1'b0;
                wr_i = 1'b0;
            end
            OP_MUL: begin
                rd_i = !OP_IMM;
                wr_i = 1'b0;
            end
            default: begin
                rd_i = !OP_IMM;
                wr_i = OP_TO_FILE && !OP_IMM;
            end
        endcase
        src_eff = resolve(src_raw, ptr0_q, ptr1_q);
        dst_eff = resolve(dst_raw, ptr0_q, ptr1_q);
    end

    // Read the source during the issue cycle
    assign mem_bus.rd_addr = phys(src_eff, bank_q);

    // Sequencer and handshake
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_EXEC;
                        ready_q <= 1'b0;
                    end
                end
                ST_EXEC: begin
                    state_q <= ST_IDLE;
                    ready_q <= 1'b1;
                    done_q  <= 1'b1;
                end
            endcase
        end
    end

    // Latch the accepted operation
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            op_q   <= OP_W_TO_FILE;
            src_q  <= 8'h00;
            dst_q  <= 8'h00;
            wr_q   <= 1'b0;
            use0_q <= 1'b0;
            use1_q <= 1'b0;
            lit_q  <= 8'h00;
            w_q    <= 8'h00;
            imm_q  <= 1'b0;
        end else if (take) begin
            op_q   <= OP_CODE;
            src_q  <= src_eff;
            dst_q  <= dst_eff;
            wr_q   <= wr_i;
            use0_q <= (rd_i && src_raw == `BDM_ADDR_IND0) ||
                      (wr_i && dst_raw == `BDM_ADDR_IND0);
            use1_q <= (rd_i && src_raw == `BDM_ADDR_IND1) ||
                      (wr_i && dst_raw == `BDM_ADDR_IND1);
            lit_q  <= OP_LIT;
            w_q    <= OP_WREG;
            imm_q  <= OP_IMM;
        end
    end

    // ----------------------------------------
    // Execute
    // ----------------------------------------
    logic [7:0]  fval;
    logic [7:0]  b_opnd;
    logic [7:0]  x_opnd;
    logic        cin;
    logic [8:0]  sum9;
    logic [4:0]  half5;
    logic [7:0]  res;
    logic [3:0]  fmask;
    logic [3:0]  fcalc;
    logic [3:0]  fnew;
    logic [15:0] prod16;
    logic        exec;
    logic        wr_file;

    assign exec    = (state_q == ST_EXEC);
    assign wr_file = exec && wr_q;

    // Source value from flops or RAM
    always_comb begin
        fval = mem_bus.rd_data;
        unique case (src_q)
            `BDM_ADDR_PTR0:  fval = ptr0_q;
            `BDM_ADDR_PTR1:  fval = ptr1_q;
            `BDM_ADDR_ALU:   fval = alu_q;
            `BDM_ADDR_BANK:  fval = bank_q;
            `BDM_ADDR_PROD_LO: fval = prod_lo_q;
            `BDM_ADDR_PROD_HI: fval = prod_hi_q;
            `BDM_ADDR_IND0, `BDM_ADDR_IND1: fval = 8'h00;
            default:         fval = mem_bus.rd_data;
        endcase
        if (imm_q) begin
            b_opnd = two_op(op_q) ? lit_q : w_q;
        end else begin
            b_opnd = fval;
        end
    end

    // Shared adder: add, subtract, increment, decrement
    always_comb begin
        x_opnd = w_q;
        cin    = 1'b0;
        unique case (op_q)
            OP_SUB: begin
                x_opnd = ~w_q;
                cin    = 1'b1;
            end
            OP_INC: begin
                x_opnd = 8'h00;
                cin    = 1'b1;
            end
            OP_DEC: begin
                x_opnd = 8'hff;
                cin    = 1'b0;
            end
            default: begin
                x_opnd = w_q;
                cin    = 1'b0;
            end
        endcase
        sum9   = {1'b0, b_opnd} + {1'b0, x_opnd} + {8'h00, cin};
        half5  = {1'b0, b_opnd[3:0]} + {1'b0, x_opnd[3:0]} + {4'h0, cin};
        prod16 = {8'h00, w_q} * {8'h00, b_opnd};
    end

    // Result and flags affected per operation
    always_comb begin
        res   = fval;
        fmask = 4'h0;
        fcalc = alu_q[3:0];
        unique case (op_q)
            OP_W_TO_FILE: res = w_q;
            OP_FILE_READ: begin
                res   = fval;
                fmask = 4'b0100;
            end
            OP_PER_TO_FILE, OP_FILE_TO_PER: res = fval;
            OP_BANK_PER, OP_BANK_RAM: res = lit_q;
            OP_ADD, OP_SUB, OP_INC, OP_DEC: begin
                res   = sum9[7:0];
                fmask = 4'b1111;
            end
            OP_AND: begin
                res   = w_q & b_opnd;
                fmask = 4'b0100;
            end
            OP_IOR: begin
                res   = w_q | b_opnd;
                fmask = 4'b0100;
            end
            OP_XOR: begin
                res   = w_q ^ b_opnd;
                fmask = 4'b0100;
            end
            OP_CLR: begin
                res   = 8'h00;
                fmask = 4'b0100;
            end
            OP_RLC: begin
                res   = {b_opnd[6:0], alu_q[`BDM_FLAG_CARRY]};
                fmask = 4'b0001;
            end
            OP_RRC: begin
                res   = {alu_q[`BDM_FLAG_CARRY], b_opnd[7:1]};
                fmask = 4'b0001;
            end
            OP_MUL: res = prod16[7:0];
        endcase
        fcalc[`BDM_FLAG_NULL]  = (res == 8'h00);
        fcalc[`BDM_FLAG_HALF]  = half5[4];
        fcalc[`BDM_FLAG_CARRY] = sum9[8];
        fcalc[`BDM_FLAG_RANGE] = (b_opnd[7] == x_opnd[7]) &&
                                 (sum9[7] != b_opnd[7]);
        if (op_q == OP_RLC) begin
            fcalc[`BDM_FLAG_CARRY] = b_opnd[7];
        end else if (op_q == OP_RRC) begin
            fcalc[`BDM_FLAG_CARRY] = b_opnd[0];
        end
        fnew = (fmask & fcalc) | (~fmask & alu_q[3:0]);
    end

    // ----------------------------------------
    // Writes
    // ----------------------------------------

    // RAM write for non-flop destinations, 8-bit wide
    assign mem_bus.wr_en   = wr_file && !special(dst_q);
    assign mem_bus.wr_addr = phys(dst_q, bank_q);
    assign mem_bus.wr_data = res;

    // Flag and pointer mode register
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            alu_q <= `BDM_ALU_RESET;
        end else if (exec) begin
            if (wr_q && dst_q == `BDM_ADDR_ALU) begin
                if (fmask != 4'h0) begin
                    alu_q <= {res[7:4], fnew};
                end else begin
                    alu_q <= res;
                end
            end else begin
                alu_q <= {alu_q[7:4], fnew};
            end
        end
    end

    // Bank select: literal loads and direct writes
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            bank_q <= `BDM_BANK_RESET;
        end else if (exec) begin
            if (op_q == OP_BANK_PER) begin
                bank_q[3:0] <= lit_q[3:0];
            end else if (op_q == OP_BANK_RAM) begin
                bank_q[7:4] <= lit_q[3:0];
            end else if (wr_q && dst_q == `BDM_ADDR_BANK) begin
                bank_q <= res;
            end
        end
    end

    // Pointer zero: write, then post step per mode
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ptr0_q <= `BDM_PTR_RESET;
        end else if (exec) begin
            if (wr_q && dst_q == `BDM_ADDR_PTR0) begin
                ptr0_q <= res;
            end else if (use0_q && !alu_q[`BDM_PTR0_MODE_LO+1]) begin
                if (alu_q[`BDM_PTR0_MODE_LO]) begin
                    ptr0_q <= ptr0_q + 8'h01;
                end else begin
                    ptr0_q <= ptr0_q - 8'h01;
                end
            end
        end
    end

    // Pointer one: write, then post step per mode
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ptr1_q <= `BDM_PTR_RESET;
        end else if (exec) begin
            if (wr_q && dst_q == `BDM_ADDR_PTR1) begin
                ptr1_q <= res;
            end else if (use1_q && !alu_q[`BDM_PTR1_MODE_LO+1]) begin
                if (alu_q[`BDM_PTR1_MODE_LO]) begin
                    ptr1_q <= ptr1_q + 8'h01;
                end else begin
                    ptr1_q <= ptr1_q - 8'h01;
                end
            end
        end
    end

    // Product bytes: multiply or direct write
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            prod_lo_q <= `BDM_PROD_RESET;
            prod_hi_q <= `BDM_PROD_RESET;
        end else if (exec) begin
            if (op_q == OP_MUL) begin
                prod_lo_q <= prod16[7:0];
                prod_hi_q <= prod16[15:8];
            end else if (wr_q && dst_q == `BDM_ADDR_PROD_LO) begin
                prod_lo_q <= res;
            end else if (wr_q && dst_q == `BDM_ADDR_PROD_HI) begin
                prod_hi_q <= res;
            end
        end
    end

    // Result byte returned to the core
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            result_q <= 8'h00;
        end else if (exec) begin
            result_q <= res;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign OP_READY  = ready_q;
    assign DONE      = done_q;
    assign RESULT    = result_q;
    assign ALU_FLAGS = alu_q;
    assign BANK_SEL  = bank_q;

endmodule

//--- sim/bdm_core_sva.sv
module bdm_core_sva (
    input logic             CLK,
    input logic             RST_B,
    input logic             OP_VALID,
    input bdm_pkg::bdm_op_t OP_CODE,
    input logic [7:0]       OP_FILE,
    input logic [4:0]       OP_PERIPH,
    input logic [7:0]       OP_LIT,
    input logic             OP_IMM,
    input logic             OP_TO_FILE,
    input logic [7:0]       OP_WREG,
    input logic             OP_READY,
    input logic             DONE,
    input logic [7:0]       RESULT,
    input logic [7:0]       ALU_FLAGS,
    input logic [7:0]       BANK_SEL
);
    timeunit 1ns;
    timeprecision 1ns;
    import bdm_pkg::*;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // --------------------------------
    // Request capture
    // --------------------------------
    logic       take;
    bdm_op_t    code_q;
    logic [7:0] lit_q;
    logic [7:0] w_q;
    logic       imm_q;

    assign take = OP_VALID && OP_READY;

    // Operands of the accepted request, kept until it completes
    always_ff @(posedge CLK) begin
        if (take) begin
            code_q <= OP_CODE;
            lit_q  <= OP_LIT;
            w_q    <= OP_WREG;
            imm_q  <= OP_IMM;
        end
    end

    // --------------------------------
    // Properties
    // --------------------------------
    property p_take_timing;
        take |=> !OP_READY ##1 (OP_READY && DONE);
    endproperty
    a_take_timing: assert property (p_take_timing)
        else $error("request did not complete two cycles after acceptance");

    property p_done_cause;
        DONE |-> $past(take, 2);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("completion without an accepted request");

    property p_hold;
        !DONE |-> $stable(RESULT) && $stable(ALU_FLAGS) && $stable(BANK_SEL);
    endproperty
    a_hold: assert property (p_hold)
        else $error("state outputs changed outside a completion");

    property p_bank_ram;
        take && OP_CODE == OP_BANK_RAM |-> ##2 BANK_SEL[5:4] == $past(OP_LIT[1:0], 2);
    endproperty
    a_bank_ram: assert property (p_bank_ram)
        else $error("ram bank load did not take the literal");

    property p_bank_per;
        take && OP_CODE == OP_BANK_PER |-> ##2 BANK_SEL[1:0] == $past(OP_LIT[1:0], 2)
            && BANK_SEL[5:4] == $past(BANK_SEL[5:4], 2);
    endproperty
    a_bank_per: assert property (p_bank_per)
        else $error("peripheral bank load wrong or disturbed ram bank");

    property p_add_imm;
        DONE && code_q == OP_ADD && imm_q |-> {ALU_FLAGS[0], RESULT} == ({1'b0, lit_q} + {1'b0, w_q});
    endproperty
    a_add_imm: assert property (p_add_imm)
        else $error("literal add sum or carry wrong");

    property p_range;
        DONE && code_q == OP_ADD && imm_q |->
            ALU_FLAGS[3] == ((lit_q[7] == w_q[7]) && (RESULT[7] != lit_q[7]));
    endproperty
    a_range: assert property (p_range)
        else $error("signed range flag wrong after add");

    property p_null;
        DONE && code_q inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR}
            |-> ALU_FLAGS[2] == (RESULT == 8'h00);
    endproperty
    a_null: assert property (p_null)
        else $error("null flag does not match result");

    property p_sub_borrow;
        DONE && code_q == OP_SUB && imm_q |-> ALU_FLAGS[0] == (lit_q >= w_q);
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("subtract carry is not the inverted borrow");

    property p_rlc;
        DONE && code_q == OP_RLC && imm_q |-> ALU_FLAGS[0] == w_q[7] && RESULT[7:1] == w_q[6:0];
    endproperty
    a_rlc: assert property (p_rlc)
        else $error("rotate left through carry wrong");

    // Main scenarios reached
    c_bank: cover property (take && OP_CODE == OP_BANK_RAM);
    c_add: cover property (DONE && code_q == OP_ADD && imm_q);
    c_sub: cover property (DONE && code_q == OP_SUB);
endmodule

//--- sim/bdm_core_tb.sv
module bdm_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bdm_pkg::*;

    logic       clk, rst_b, op_valid, op_imm, op_to_file, op_ready, done;
    bdm_op_t    op_code;
    logic [7:0] op_file, op_lit, op_wreg, result, alu_flags, bank_sel;
    logic [4:0] op_periph;
    int         err_total, checked, cycles;

    bdm_core dut (
        .CLK(clk), .RST_B(rst_b), .OP_VALID(op_valid), .OP_CODE(op_code),
        .OP_FILE(op_file), .OP_PERIPH(op_periph), .OP_LIT(op_lit), .OP_IMM(op_imm),
        .OP_TO_FILE(op_to_file), .OP_WREG(op_wreg), .OP_READY(op_ready), .DONE(done),
        .RESULT(result), .ALU_FLAGS(alu_flags), .BANK_SEL(bank_sel)
    );

    always #25 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            test_done;
        end
    end

    // --------------------------------
    // Shared tasks
    // --------------------------------
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One request: driven at an edge, taken at the next, done one edge later
    task automatic op(input bdm_op_t c, input logic [7:0] f, input logic [4:0] p,
                      input logic [7:0] l, input logic i, input logic t, input logic [7:0] w);
        @(posedge clk);
        op_valid   <= 1'b1;
        op_code    <= c;
        op_file    <= f;
        op_periph  <= p;
        op_lit     <= l;
        op_imm     <= i;
        op_to_file <= t;
        op_wreg    <= w;
        @(posedge clk);
        op_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk("done", {7'h00, done}, 8'h01);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        op(OP_W_TO_FILE, a, 5'h00, 8'h00, 1'b0, 1'b1, v);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        op(OP_FILE_READ, a, 5'h00, 8'h00, 1'b0, 1'b0, 8'h00);
        chk("file", result, exp);
    endtask

    task automatic bk(input bdm_op_t c, input logic [7:0] v);
        op(c, 8'h00, 5'h00, v, 1'b0, 1'b0, 8'h00);
    endtask

    task automatic alu(input bdm_op_t c, input logic [7:0] l, input logic [7:0] w,
                       input logic [7:0] r, input logic [3:0] fl);
        op(c, 8'h00, 5'h00, l, 1'b1, 1'b0, w);
        chk("result", result, r);
        chk("flags", {4'h0, alu_flags[3:0]}, {4'h0, fl});
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_reset;
        #1;
        chk("flags", alu_flags, 8'hf0);
        chk("bank", bank_sel, 8'h00);
        chk("ready", {7'h00, op_ready}, 8'h01);
    endtask

    task automatic t_bank;
        wr(8'h20, 8'ha1);
        wr(8'h1a, 8'hc3);
        bk(OP_BANK_RAM, 8'h01);
        bk(OP_BANK_PER, 8'h02);
        chk("bank", bank_sel, 8'h12);
        wr(8'h20, 8'hb2);
        wr(8'h10, 8'h55);
        rd(8'h1a, 8'hc3);
        bk(OP_BANK_PER, 8'h03);
        wr(8'h10, 8'h66);
        wr(8'h18, 8'h77);
        bk(OP_BANK_PER, 8'h02);
        rd(8'h10, 8'h55);
        rd(8'h18, 8'h77);
        do_reset;
        rd(8'h20, 8'ha1);
        bk(OP_BANK_RAM, 8'h01);
        rd(8'h20, 8'hb2);
    endtask

    task automatic t_move;
        for (int p = 8'h1a; p <= 8'h1f; p++) begin
            wr(8'h30, 8'h40 + 8'(p));
            op(OP_FILE_TO_PER, 8'h30, 5'(p), 8'h00, 1'b0, 1'b0, 8'h00);
        end
        for (int p = 8'h1a; p <= 8'h1f; p++) begin
            op(OP_PER_TO_FILE, 8'hff, 5'(p), 8'h00, 1'b0, 1'b0, 8'h00);
            rd(8'hff, 8'h40 + 8'(p));
        end
    endtask

    task automatic t_ptr;
        bk(OP_BANK_RAM, 8'h00);
        wr(8'h41, 8'hee);
        bk(OP_BANK_RAM, 8'h01);
        wr(8'h04, 8'h90);
        wr(8'h01, 8'h40);
        wr(8'h00, 8'h11);
        wr(8'h00, 8'h22);
        rd(8'h01, 8'h42);
        rd(8'h41, 8'h22);
        wr(8'h08, 8'h99);
        rd(8'h09, 8'h00);
        wr(8'h04, 8'h60);
        wr(8'h09, 8'h70);
        wr(8'h08, 8'h33);
        wr(8'h00, 8'h66);
        rd(8'h09, 8'h71);
        rd(8'h01, 8'h42);
        wr(8'h04, 8'h00);
        wr(8'h08, 8'h44);
        wr(8'h00, 8'h55);
        rd(8'h09, 8'h70);
        rd(8'h01, 8'h41);
        bk(OP_BANK_RAM, 8'h00);
        rd(8'h41, 8'hee);
    endtask

    task automatic t_alu;
        wr(8'h04, 8'hf0);
        alu(OP_ADD, 8'h7f, 8'h01, 8'h80, 4'ha);
        alu(OP_ADD, 8'hff, 8'h01, 8'h00, 4'h7);
        alu(OP_SUB, 8'h10, 8'h01, 8'h0f, 4'h1);
        alu(OP_SUB, 8'h00, 8'h01, 8'hff, 4'h0);
        alu(OP_SUB, 8'h80, 8'h01, 8'h7f, 4'h9);
        alu(OP_AND, 8'hf0, 8'h0f, 8'h00, 4'hd);
        alu(OP_IOR, 8'hf0, 8'h0f, 8'hff, 4'h9);
        alu(OP_XOR, 8'hff, 8'hff, 8'h00, 4'hd);
        alu(OP_RLC, 8'h00, 8'h40, 8'h81, 4'hc);
        alu(OP_RRC, 8'h00, 8'h01, 8'h00, 4'hd);
        alu(OP_MUL, 8'h12, 8'h34, 8'ha8, 4'hd);
        rd(8'h19, 8'h03);
        wr(8'h21, 8'h7f);
        op(OP_INC, 8'h21, 5'h00, 8'h00, 1'b0, 1'b1, 8'h00);
        rd(8'h21, 8'h80);
        wr(8'h04, 8'h30);
        op(OP_ADD, 8'h04, 5'h00, 8'h00, 1'b0, 1'b1, 8'hd0);
        chk("flags", alu_flags, 8'h05);
        wr(8'h04, 8'h3b);
        op(OP_CLR, 8'h04, 5'h00, 8'h00, 1'b0, 1'b1, 8'h00);
        chk("flags", alu_flags, 8'h0f);
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        op_valid = 1'b0;
        op_code = OP_W_TO_FILE;
        op_file = 8'h00;
        op_periph = 5'h00;
        op_lit = 8'h00;
        op_imm = 1'b0;
        op_to_file = 1'b0;
        op_wreg = 8'h00;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_bank;
        t_move;
        t_ptr;
        t_alu;
        test_done;
    end
endmodule

bind bdm_core bdm_core_sva chk_i (
    .CLK(CLK), .RST_B(RST_B), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_FILE(OP_FILE), .OP_PERIPH(OP_PERIPH), .OP_LIT(OP_LIT), .OP_IMM(OP_IMM),
    .OP_TO_FILE(OP_TO_FILE), .OP_WREG(OP_WREG), .OP_READY(OP_READY), .DONE(DONE),
    .RESULT(RESULT), .ALU_FLAGS(ALU_FLAGS), .BANK_SEL(BANK_SEL)
);
